// >>> hdl/pps_top.sv
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
module pps_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [pps_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [pps_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [pps_pkg::STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pps_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [pps_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [pps_pkg::SIG_TOTAL-1:0] per_out,
  input wire logic [pps_pkg::SIG_TOTAL-1:0] per_oe,
  output logic [pps_pkg::SIG_TOTAL-1:0] per_in,
  input wire logic [pps_pkg::PAD_TOTAL-1:0] pad_in,
  output logic [pps_pkg::PAD_TOTAL-1:0] pad_out,
  output logic [pps_pkg::PAD_TOTAL-1:0] pad_oe,
  output logic [pps_pkg::OWN_TOTAL-1:0] pad_own,
  output logic fourwire_active
);
  import pps_pkg::*;

  logic [DATA_W-1:0] reg_first;
  logic [DATA_W-1:0] reg_second;
  logic [DATA_W-1:0] reg_ctrl;
  logic [ADDR_W-1:0] aw_addr;
  logic aw_full;
  logic [DATA_W-1:0] w_data;
  logic [STRB_W-1:0] w_strb;
  logic w_full;
  logic do_write;
  logic wr_hit;
  logic [DATA_W-1:0] next_first;
  logic [DATA_W-1:0] next_second;
  logic [DATA_W-1:0] next_ctrl;
  logic [SEL_W-1:0] sel_g [GROUPS];
  pps_rd_t rd_kind;

  function automatic logic [DATA_W-1:0] merge(
    input logic [DATA_W-1:0] old,
    input logic [DATA_W-1:0] data,
    input logic [STRB_W-1:0] strb
  );
    logic [DATA_W-1:0] m;
    m = '0;
    for (int b = 0; b < STRB_W; b++) begin
      m[b*8 +: 8] = {8{strb[b]}};
    end
    return (old & ~m) | (data & m);
  endfunction

  function automatic pps_rd_t decode(input logic [ADDR_W-1:0] a);
    pps_rd_t k;
    k = PPS_RD_NONE;
    if (a == OFF_FIRST) begin
      k = PPS_RD_FIRST;
    end else if (a == OFF_SECOND) begin
      k = PPS_RD_SECOND;
    end else if (a == OFF_CTRL) begin
      k = PPS_RD_CTRL;
    end
    return k;
  endfunction

  // A write happens once both halves are held and the previous answer has gone.
  assign do_write = aw_full & w_full & ~s_axi_bvalid;
  assign wr_hit = (decode(aw_addr) != PPS_RD_NONE);

  always_comb begin
    next_first = merge(reg_first, w_data, w_strb) & MASK_FIRST; // [RULE6]
    next_ctrl = merge(reg_ctrl, w_data, w_strb) & MASK_CTRL;
    next_second = merge(reg_second, w_data, w_strb) & MASK_SECOND; // [RULE6]
    // The reserved channel3 code would leave the channel on no pad, so it is refused.
    if (next_second[F_T2C3 +: 2] == T2C3_RSVD) begin
      next_second[F_T2C3 +: 2] = reg_second[F_T2C3 +: 2]; // [RULE16]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      aw_full <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_addr <= s_axi_awaddr;
      aw_full <= 1'b1;
      s_axi_awready <= 1'b0;
    end else if (do_write) begin
      aw_full <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      w_full <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
      w_full <= 1'b1;
      s_axi_wready <= 1'b0;
    end else if (do_write) begin
      w_full <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reg_first <= RESET_REG;
      reg_second <= RESET_REG;
      reg_ctrl <= RESET_REG;
    end else if (do_write) begin
      case (decode(aw_addr))
        PPS_RD_FIRST: begin
          reg_first <= next_first;
        end
        PPS_RD_SECOND: begin
          reg_second <= next_second;
        end
        PPS_RD_CTRL: begin
          reg_ctrl <= next_ctrl;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
      rd_kind <= PPS_RD_NONE;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      rd_kind <= decode(s_axi_araddr);
      s_axi_rresp <= RESP_OKAY;
      case (decode(s_axi_araddr))
        PPS_RD_FIRST: begin
          s_axi_rdata <= reg_first; // [RULE6]
        end
        PPS_RD_SECOND: begin
          s_axi_rdata <= reg_second; // [RULE6]
        end
        PPS_RD_CTRL: begin
          s_axi_rdata <= reg_ctrl;
        end
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Single-bit selectors are zero-extended to the common selector width.
  always_comb begin
    sel_g[0] = SEL_W'(reg_first[F_T0C0]); // [RULE1]
    sel_g[1] = SEL_W'(reg_first[F_U0]); // [RULE2]
    sel_g[2] = SEL_W'(reg_first[F_SPI0]); // [RULE3]
    sel_g[3] = SEL_W'(reg_first[F_I2C0]); // [RULE4]
    sel_g[4] = SEL_W'(reg_first[F_RTC]); // [RULE5]
    sel_g[5] = reg_first[F_IRQ +: SEL_W]; // [RULE7]
    sel_g[6] = SEL_W'(reg_second[F_PWT1]); // [RULE8]
    sel_g[7] = SEL_W'(reg_second[F_PWT0]); // [RULE9]
    sel_g[8] = SEL_W'(reg_second[F_U2]); // [RULE10]
    sel_g[9] = SEL_W'(reg_second[F_U1]); // [RULE11]
    sel_g[10] = SEL_W'(reg_second[F_SPI1]); // [RULE12]
    sel_g[11] = SEL_W'(reg_second[F_I2C1]); // [RULE13]
    sel_g[12] = SEL_W'(reg_second[F_T2C5]); // [RULE14]
    sel_g[13] = SEL_W'(reg_second[F_T2C4]); // [RULE15]
    sel_g[14] = SEL_W'(reg_second[F_T2C3 +: 2]); // [RULE16]
  end

  for (genvar g = 0; g < GROUPS; g++) begin : g_grp
    pps_route #(
      .W(G_W[g]),
      .N(G_N[g])
    ) u_route (
      .aclk(aclk),
      .aresetn(aresetn),
      .sel(sel_g[g]),
      .per_out(per_out[G_S[g] +: G_W[g]]),
      .per_oe(per_oe[G_S[g] +: G_W[g]]),
      .per_in(per_in[G_S[g] +: G_W[g]]),
      .pad_in(pad_in[G_P[g] +: G_W[g]*G_N[g]]),
      .pad_out(pad_out[G_P[g] +: G_W[g]*G_N[g]]),
      .pad_oe(pad_oe[G_P[g] +: G_W[g]*G_N[g]]),
      .pad_own(pad_own[G_O[g] +: G_N[g]])
    );
  end

  // The four-wire option has no meaning on the alternate pair, so it is masked there.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fourwire_active <= 1'b0;
    end else begin
      fourwire_active <= reg_ctrl[F_FOURWIRE] & ~reg_first[F_I2C0]; // [RULE17]
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_T0C0_ROUTE: assert property ( // [RULE1]
    per_oe[G_S[0]] |=> pad_oe[G_P[0] + $past(reg_first[F_T0C0])]
      && !pad_oe[G_P[0] + !$past(reg_first[F_T0C0])])
    else $error("timer0 channel0 not on its selected pad");

  AST_UART0_PAIR: assert property ( // [RULE2]
    1'b1 |=> pad_own[G_O[1] + 1] == $past(reg_first[F_U0])
      && pad_own[G_O[1]] == !$past(reg_first[F_U0]))
    else $error("serial0 pair not on its selected pads");

  AST_SPI0_GROUP: assert property ( // [RULE3]
    reg_first[F_SPI0] |=> pad_out[G_P[2] + 4 +: 4] == $past(per_out[G_S[2] +: 4])
      && pad_oe[G_P[2] + 4 +: 4] == $past(per_oe[G_S[2] +: 4]) && pad_oe[G_P[2] +: 4] == '0)
    else $error("spi port0 group split across pad sets");

  AST_I2C0_PAIR: assert property ( // [RULE4]
    !reg_first[F_I2C0] && per_oe[G_S[3] +: 2] != '0
      |=> pad_oe[G_P[3] + 2 +: 2] == '0 && pad_own[G_O[3]])
    else $error("two-wire port0 drives the alternate pair");

  AST_RTC_PIN: assert property ( // [RULE5]
    !reg_first[F_RTC] && per_out[G_S[4]] && per_oe[G_S[4]]
      |=> pad_out[G_P[4]] && !pad_oe[G_P[4] + 1])
    else $error("clock output not on first pin");

  AST_RSVD_ZERO: assert property ( // [RULE6]
    s_axi_rvalid && rd_kind == PPS_RD_FIRST |-> !s_axi_rdata[F_RES3]
      ##0 (rd_kind != PPS_RD_SECOND || s_axi_rdata[DATA_W-1:RES_HI_LSB] == '0))
    else $error("reserved bit read back as one");

  AST_RSVD_HI: assert property ( // [RULE6]
    s_axi_rvalid && rd_kind == PPS_RD_SECOND |-> s_axi_rdata[DATA_W-1:RES_HI_LSB] == '0)
    else $error("reserved upper bits read back nonzero");

  AST_IRQ_SELECT: assert property ( // [RULE7]
    1'b1 |=> pad_own[G_O[5] +: 8] == 8'(8'h01 << $past(reg_first[F_IRQ +: SEL_W])))
    else $error("interrupt input on wrong pad");

  sequence s_rsvd_write;
    do_write && decode(aw_addr) == PPS_RD_SECOND && w_strb[0]
      && w_data[F_T2C3 +: 2] == T2C3_RSVD;
  endsequence

  sequence s_code_kept(logic [1:0] old);
    reg_second[F_T2C3 +: 2] == old ##1 pad_own[G_O[14] +: 3] != '0;
  endsequence

  property p_rsvd_refused;
    logic [1:0] old;
    (s_rsvd_write, old = reg_second[F_T2C3 +: 2]) |=> s_code_kept(old);
  endproperty

  AST_T2C3_REFUSED: assert property (p_rsvd_refused) // [RULE16]
    else $error("reserved channel3 code was stored");

  AST_FOURWIRE_GATE: assert property ( // [RULE17]
    reg_first[F_I2C0] |=> !fourwire_active)
    else $error("four-wire option active on alternate pins");

  AST_ONE_PAD: assert property ( // [RULE18]
    $onehot(pad_own[G_O[5] +: 8]) && $onehot(pad_own[G_O[14] +: 3])
      && $onehot(pad_own[G_O[10] +: 2]))
    else $error("a group owns other than one pad");

  sequence s_both_held;
    aw_full && w_full && !s_axi_bvalid;
  endsequence

  sequence s_resp_out;
    s_axi_bvalid && s_axi_awready && s_axi_wready;
  endsequence

  AST_WRITE_RESP: assert property (s_both_held |=> s_resp_out)
    else $error("write answer missing one cycle after both halves");

  AST_READ_RESP: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer missing one cycle after address");
endmodule

// >>> hdl/pps_pkg.sv
// How it works
// RULE1: Timer0 channel0 goes primary or alternate pin.
// RULE2: Serial0 receive and transmit move as pair.
// RULE3: SPI port0 four signals switch together.
// RULE4: Two-wire port0 clock and data switch together.
// RULE5: Clock output goes first or second pin.
// RULE6: Reserved bits read zero, ignore writes; the code stores bits 5:0 of the second register and reads them back.
// RULE7: Interrupt input chooses one of eight pins.
// RULE8: Pulse timer input1 first or alternate pin.
// RULE9: Pulse timer input0 first or alternate pin.
// RULE10: Serial2 transmit and receive switch together.
// RULE11: Serial1 transmit and receive switch together.
// RULE12: SPI port1 four signals switch together.
// RULE13: Two-wire port1 clock and data switch together.
// RULE14: Timer2 channel5 primary or alternate pin.
// RULE15: Timer2 channel4 primary or alternate pin.
// RULE16: Timer2 channel3 three pins, code 11 refused.
// RULE17: Four-wire option works only with selector clear.
// RULE18: Each signal owns exactly one pad always.
package pps_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int SEL_W = 3;

  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_FIRST = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_SECOND = 8'h10;

  localparam logic [DATA_W-1:0] MASK_FIRST = 32'h0000_01F7;
  localparam logic [DATA_W-1:0] MASK_SECOND = 32'h0000_FFFF;
  localparam logic [DATA_W-1:0] MASK_CTRL = 32'h0000_0001;
  localparam logic [DATA_W-1:0] RESET_REG = 32'h0000_0000;

  localparam int F_T0C0 = 8;
  localparam int F_U0 = 7;
  localparam int F_SPI0 = 6;
  localparam int F_I2C0 = 5;
  localparam int F_RTC = 4;
  localparam int F_RES3 = 3;
  localparam int F_IRQ = 0;
  localparam int F_PWT1 = 15;
  localparam int F_PWT0 = 14;
  localparam int F_U2 = 13;
  localparam int F_U1 = 12;
  localparam int F_SPI1 = 11;
  localparam int F_I2C1 = 10;
  localparam int F_T2C5 = 9;
  localparam int F_T2C4 = 8;
  localparam int F_T2C3 = 6;
  localparam int F_FOURWIRE = 0;
  localparam int RES_HI_LSB = 16;

  localparam logic [1:0] T2C3_RSVD = 2'b11;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  localparam int GROUPS = 15;
  localparam int SIG_TOTAL = 26;
  localparam int PAD_TOTAL = 59;
  localparam int OWN_TOTAL = 37;
  // Group order: t0c0 u0 spi0 i2c0 rtc irq pwt1 pwt0 u2 u1 spi1 i2c1 t2c5 t2c4 t2c3.
  localparam int G_W [GROUPS] = '{1, 2, 4, 2, 1, 1, 1, 1, 2, 2, 4, 2, 1, 1, 1};
  localparam int G_N [GROUPS] = '{2, 2, 2, 2, 2, 8, 2, 2, 2, 2, 2, 2, 2, 2, 3};
  localparam int G_S [GROUPS] = '{0, 1, 3, 7, 9, 10, 11, 12, 13, 15, 17, 21, 23, 24, 25};
  localparam int G_P [GROUPS] = '{0, 2, 6, 14, 18, 20, 28, 30, 32, 36, 40, 48, 52, 54, 56};
  localparam int G_O [GROUPS] = '{0, 2, 4, 6, 8, 10, 18, 20, 22, 24, 26, 28, 30, 32, 34};

  typedef enum logic [1:0] {
    PPS_RD_NONE = 2'b00,
    PPS_RD_FIRST = 2'b01,
    PPS_RD_SECOND = 2'b10,
    PPS_RD_CTRL = 2'b11
  } pps_rd_t;
endpackage

// >>> hdl/pps_route.sv
`timescale 1ns/1ps
// One peripheral group routed onto one of N pad sets; pad index is set*W + signal.
module pps_route #(
  parameter int W = 1,
  parameter int N = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [pps_pkg::SEL_W-1:0] sel,
  input wire logic [W-1:0] per_out,
  input wire logic [W-1:0] per_oe,
  output logic [W-1:0] per_in,
  input wire logic [W*N-1:0] pad_in,
  output logic [W*N-1:0] pad_out,
  output logic [W*N-1:0] pad_oe,
  output logic [N-1:0] pad_own
);
  import pps_pkg::*;

  // Unselected pads drive nothing and report free, so their other functions can use them.
  for (genvar k = 0; k < N; k++) begin : g_set
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pad_own[k] <= (k == 0);
      end else begin
        pad_own[k] <= (int'(sel) == k); // [RULE18]
      end
    end
    for (genvar i = 0; i < W; i++) begin : g_sig
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pad_out[k*W+i] <= 1'b0;
          pad_oe[k*W+i] <= 1'b0;
        end else begin
          pad_out[k*W+i] <= (int'(sel) == k) & per_out[i]; // [RULE18]
          pad_oe[k*W+i] <= (int'(sel) == k) & per_oe[i];
        end
      end
    end
  end

  for (genvar i = 0; i < W; i++) begin : g_in
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        per_in[i] <= 1'b0;
      end else if (int'(sel) < N) begin
        per_in[i] <= pad_in[int'(sel)*W+i];
      end else begin
        per_in[i] <= 1'b0;
      end
    end
  end
endmodule

// >>> tb/peripheral_pin_select_tb.sv
`timescale 1ns/1ps
module peripheral_pin_select_tb;
  import pps_pkg::*;
  logic aclk, aresetn;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [STRB_W-1:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [SIG_TOTAL-1:0] per_out, per_oe, per_in;
  logic [PAD_TOTAL-1:0] pad_in, pad_out, pad_oe;
  logic [OWN_TOTAL-1:0] pad_own;
  logic fourwire_active;
  int err_count, checks;
  // Field position of each group selector, in the package's group order.
  localparam int FBIT [GROUPS] = '{F_T0C0, F_U0, F_SPI0, F_I2C0, F_RTC, F_IRQ, F_PWT1, F_PWT0,
    F_U2, F_U1, F_SPI1, F_I2C1, F_T2C5, F_T2C4, F_T2C3};

  pps_top i_pps_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .per_out(per_out), .per_oe(per_oe), .per_in(per_in),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_own(pad_own),
    .fourwire_active(fourwire_active));

  initial begin
    aclk = 1'h0;
    forever #4 aclk = ~aclk;
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Address and data are offered together; each is released only once taken.
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    bit aw_done, w_done;
    aw_done = 0;
    w_done = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready === 1'h1) begin
        aw_done = 1;
        s_axi_awvalid <= 1'h0;
      end
      if (!w_done && s_axi_wready === 1'h1) begin
        w_done = 1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] q);
    logic [1:0] r;
    axi_write(a, d, s, r);
    chk(r, RESP_OKAY);
    axi_read(a, q, r);
    chk(r, RESP_OKAY);
  endtask

  task automatic test_reset();
    logic [63:0] own;
    logic [31:0] q;
    logic [1:0] r;
    own = 0;
    for (int g = 0; g < GROUPS; g++) own[G_O[g]] = 1'h1;
    chk(pad_own, own);
    chk(pad_out, 0);
    chk(pad_oe, 0);
    chk(fourwire_active, 0);
    axi_read(OFF_FIRST, q, r);
    chk(q, RESET_REG);
    axi_read(OFF_SECOND, q, r);
    chk(q, RESET_REG);
  endtask

  task automatic test_masks();
    logic [31:0] q;
    wr_rd(OFF_FIRST, 32'hFFFF_FFFF, 4'hF, q);
    chk(q, MASK_FIRST);
    wr_rd(OFF_SECOND, 32'hFFFF_FFFF, 4'hF, q);
    chk(q, 32'h0000_FF3F);
    wr_rd(OFF_SECOND, 32'h0000_0080, 4'hF, q);
    wr_rd(OFF_SECOND, 32'h0000_00C0, 4'hF, q);
    chk(q, 32'h0000_0080);
    wr_rd(OFF_SECOND, 32'h0000_4000, 4'h1, q);
    chk(q, 32'h0000_0000);
    wr_rd(OFF_FIRST, 32'h0000_0000, 4'hF, q);
  endtask

  task automatic test_unmapped();
    logic [31:0] q;
    logic [1:0] r;
    axi_write(8'h20, 32'hFFFF_FFFF, 4'hF, r);
    chk(r, RESP_SLVERR);
    axi_read(8'h20, q, r);
    chk({q, r}, {32'h0000_0000, RESP_SLVERR});
  endtask

  // The four-wire option must drop as soon as the two-wire port leaves its first pin pair.
  task automatic test_fourwire();
    logic [31:0] q;
    wr_rd(OFF_CTRL, 32'hFFFF_FFFF, 4'hF, q);
    chk(q, MASK_CTRL);
    chk(fourwire_active, 1'h1);
    wr_rd(OFF_FIRST, 32'h0000_0001 << F_I2C0, 4'hF, q);
    chk(fourwire_active, 1'h0);
    wr_rd(OFF_FIRST, 32'h0000_0000, 4'hF, q);
    wr_rd(OFF_CTRL, 32'h0000_0000, 4'hF, q);
  endtask

  // Every code of every group, with a pattern and its inverse so stuck bits show.
  task automatic test_routes();
    logic [31:0] v, q;
    logic [7:0] a;
    logic [63:0] eo, ee, go, ge, ei, gi, ew, gw;
    int w;
    for (int p = 0; p < 2; p++) begin
      per_out <= p ? ~26'h2D5_A5C3 : 26'h2D5_A5C3;
      per_oe <= p ? ~26'h1A6_3C59 : 26'h1A6_3C59;
      pad_in <= p ? ~59'h5A3_C96E_1B47_D28F : 59'h5A3_C96E_1B47_D28F;
      for (int g = 0; g < GROUPS; g++) begin
        a = (g < 6) ? OFF_FIRST : OFF_SECOND;
        w = G_W[g];
        for (int s = 0; s < G_N[g]; s++) begin
          v = 32'(s) << FBIT[g];
          wr_rd(a, v, 4'hF, q);
          chk(q, v);
          @(negedge aclk);
          {eo, ee, go, ge, ei, gi, ew, gw} = '0;
          for (int k = 0; k < w * G_N[g]; k++) begin
            if (k / w == s) begin
              eo[k] = per_out[G_S[g] + k % w];
              ee[k] = per_oe[G_S[g] + k % w];
            end
            go[k] = pad_out[G_P[g] + k];
            ge[k] = pad_oe[G_P[g] + k];
          end
          for (int k = 0; k < w; k++) begin
            ei[k] = pad_in[G_P[g] + s * w + k];
            gi[k] = per_in[G_S[g] + k];
          end
          for (int k = 0; k < G_N[g]; k++) begin
            ew[k] = (k == s);
            gw[k] = pad_own[G_O[g] + k];
          end
          chk(go, eo);
          chk(ge, ee);
          chk(gi, ei);
          chk(gw, ew);
          @(posedge aclk);
        end
      end
    end
  endtask

  // A reset in mid-run must clear every selector and release every alternate pad.
  task automatic test_mid_reset();
    {per_out, per_oe, pad_in} <= '0;
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    test_reset();
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    final_report();
  end

  initial begin
    err_count = 0;
    checks = 0;
    aresetn <= 1'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
    {per_out, per_oe, pad_in} <= '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    test_reset();
    test_masks();
    test_unmapped();
    test_fourwire();
    test_routes();
    test_mid_reset();
    final_report();
  end
endmodule
